// ---- logic/cbl_cmp_flags.sv ----
// subtract-compare flag generator, no result is written back
`timescale 1ns/100ps
module cbl_cmp_flags (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       use_carry,
	input  wire logic [7:0] flags_in,
	output logic      [7:0] flags_out
);
	logic [7:0] r;
	logic       cin;

	// flags follow the borrow chain of a - b - c
	always_comb
	begin
		cin = use_carry & flags_in[cbl_pkg::F_C];
		r   = a - b - {7'h00, cin};
		flags_out = flags_in;
		flags_out[cbl_pkg::F_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		flags_out[cbl_pkg::F_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		flags_out[cbl_pkg::F_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		flags_out[cbl_pkg::F_N] = r[7];
		// with carry, zero only stays set across a chained compare
		flags_out[cbl_pkg::F_Z] = (r == 8'h00)
			& (~use_carry | flags_in[cbl_pkg::F_Z]);
		flags_out[cbl_pkg::F_S] = r[7] ^ flags_out[cbl_pkg::F_V];
	end
endmodule : cbl_cmp_flags

// ---- logic/cbl_exec.sv ----
// execution core for compare/skip, flag branches and data loads
// Summary of operation
// - compare-skip-equal skips next instruction on equal; flags kept; 1/2/3 cycles
// - compare forms subtract without write-back, update six flags in one cycle
// - register bit skips skip on cleared or set bit; 1/2/3 cycles
// - I/O bit skips skip on cleared or set bit; 2/3/4 cycles
// - flag branches test selected bit; taken target pc+k+1; 1 or 2 cycles
// - carry branches: lower when carry one, same-or-higher when zero
// - signed ge when N xor V is zero, signed lt when one
// - half-carry branches test H for one or zero
// - transfer-bit branches test T for one or zero
// - overflow branches test V for one or zero
// - interrupt branches test I for one or zero, I unchanged
// - direct load copies byte at absolute address; two cycles plus waits
// - pointer load reads in one cycle; post-increment form bumps pointer
// - pre-decrement load lowers pointer first, then reads; two cycles
`timescale 1ns/100ps
module cbl_exec (
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	output logic             [15:0] pc,
	input  wire cbl_pkg::cbl_instr_t prog_instr,
	output cbl_pkg::cbl_dreq_t      dmem,
	input  wire logic         [7:0] dmem_rdata,
	input  wire logic               dmem_ready,
	input  wire logic               flags_wr,
	input  wire logic         [7:0] flags_wdata,
	output logic              [7:0] status_flags,
	input  wire logic         [4:0] peek_sel,
	output logic              [7:0] peek_data
);
	typedef enum {ST_EXEC, ST_SKIP, ST_SKIP2, ST_IOTEST, ST_BRTAKE,
		ST_LOAD, ST_POPH, ST_POPL, ST_RETEND} cbl_state_t;

	cbl_state_t           state_reg, state_next;
	logic [15:0]          pc_reg, pc_next;
	logic [15:0]          sp_reg, sp_next;
	logic [15:0]          addr_reg, addr_next;
	logic [7:0]           flags_reg, flags_next;
	logic [4:0]           dst_reg, dst_next;
	logic [2:0]           bsel_reg, bsel_next;
	logic                 want_reg, want_next;
	logic                 iret_reg, iret_next;
	logic [7:0]           pch_reg, pch_next;
	logic [31:0][7:0]     rf_reg, rf_next;
	logic [7:0]           cmp_b;
	logic [7:0]           cmp_flags;
	logic                 br_hit;
	logic [15:0]          ptr;
	logic [15:0]          br_target;
	cbl_pkg::cbl_instr_t  ins;

	// pointer pair value and its low register index
	function automatic logic [4:0] ptr_lo(input logic [1:0] s);
		ptr_lo = (s == cbl_pkg::PSEL_X) ? cbl_pkg::PTR_X_LO :
			(s == cbl_pkg::PSEL_Y) ? cbl_pkg::PTR_Y_LO : cbl_pkg::PTR_Z_LO;
	endfunction : ptr_lo

	function automatic logic [15:0] ptr_val(input logic [31:0][7:0] rf,
		input logic [1:0] s);
		ptr_val = {rf[ptr_lo(s) + 5'h01], rf[ptr_lo(s)]};
	endfunction : ptr_val

	assign ins          = prog_instr;
	assign pc           = pc_reg;
	assign status_flags = flags_reg;
	assign peek_data    = rf_reg[peek_sel];
	assign cmp_b        = (ins.op == cbl_pkg::OP_CMPIMM) ? ins.imm : rf_reg[ins.rr];
	assign ptr          = ptr_val(rf_reg, ins.ptr);
	assign br_target    = pc_reg + 16'h0001 + {{9{ins.koff[6]}}, ins.koff};

	// one bit index covers every named flag branch
	// equal/minus use Z/N, carry C, half H, transfer T, overflow V, irq I
	always_comb
	begin
		case (ins.op)
			cbl_pkg::OP_BRSET: br_hit = flags_reg[ins.bsel];
			cbl_pkg::OP_BRCLR: br_hit = ~flags_reg[ins.bsel];
			cbl_pkg::OP_BRSGE: br_hit = ~(flags_reg[cbl_pkg::F_N] ^ flags_reg[cbl_pkg::F_V]);
			cbl_pkg::OP_BRSLT: br_hit = flags_reg[cbl_pkg::F_N] ^ flags_reg[cbl_pkg::F_V];
			default:           br_hit = 1'b0;
		endcase
	end

	cbl_cmp_flags u_cmp (
		.a         (rf_reg[ins.rd]),
		.b         (cmp_b),
		.use_carry (ins.op == cbl_pkg::OP_CMPCARRY),
		.flags_in  (flags_reg),
		.flags_out (cmp_flags)
	);

	// next-state logic of the whole core; data reads are issued from here
	// so that a ready memory completes a pointer load in the same cycle
	always_comb
	begin
		state_next = state_reg;
		pc_next    = pc_reg;
		sp_next    = sp_reg;
		addr_next  = addr_reg;
		flags_next = flags_wr ? flags_wdata : flags_reg;
		dst_next   = dst_reg;
		bsel_next  = bsel_reg;
		want_next  = want_reg;
		iret_next  = iret_reg;
		pch_next   = pch_reg;
		rf_next    = rf_reg;
		dmem       = '0;
		case (state_reg)
			ST_EXEC:
			begin
				pc_next = pc_reg + 16'h0001;
				dst_next = ins.rd;
				case (ins.op)
					cbl_pkg::OP_CMPSKIP:
						if (rf_reg[ins.rd] == rf_reg[ins.rr])
							state_next = ST_SKIP;
					cbl_pkg::OP_CP, cbl_pkg::OP_CMPCARRY, cbl_pkg::OP_CMPIMM:
						flags_next = cmp_flags;
					cbl_pkg::OP_SRBC, cbl_pkg::OP_SRBS:
						if (rf_reg[ins.rr][ins.bsel] == (ins.op == cbl_pkg::OP_SRBS))
							state_next = ST_SKIP;
					cbl_pkg::OP_SIOC, cbl_pkg::OP_SIOS:
					begin
						// the I/O bit is only known after a data read
						addr_next  = cbl_pkg::IO_BASE + {10'h000, ins.addr[5:0]};
						bsel_next  = ins.bsel;
						want_next  = (ins.op == cbl_pkg::OP_SIOS);
						state_next = ST_IOTEST;
					end
					cbl_pkg::OP_BRSET, cbl_pkg::OP_BRCLR,
					cbl_pkg::OP_BRSGE, cbl_pkg::OP_BRSLT:
						if (br_hit)
						begin
							pc_next    = br_target;
							state_next = ST_BRTAKE;
						end
					cbl_pkg::OP_MOV:
						rf_next[ins.rd] = rf_reg[ins.rr];
					cbl_pkg::OP_CPYPAIR:
					begin
						rf_next[ins.rd] = rf_reg[ins.rr];
						rf_next[ins.rd + 5'h01] = rf_reg[ins.rr + 5'h01];
					end
					cbl_pkg::OP_LDCONST:
						rf_next[ins.rd] = ins.imm;
					cbl_pkg::OP_LDD:
					begin
						pc_next    = pc_reg + 16'h0002;
						addr_next  = ins.addr;
						state_next = ST_LOAD;
					end
					cbl_pkg::OP_LDP, cbl_pkg::OP_LDPOST:
					begin
						dmem.req  = 1'b1;
						dmem.addr = ptr;
						addr_next = ptr;
						if (ins.op == cbl_pkg::OP_LDPOST)
							{rf_next[ptr_lo(ins.ptr) + 5'h01], rf_next[ptr_lo(ins.ptr)]}
								= ptr + 16'h0001;
						if (dmem_ready)
							rf_next[ins.rd] = dmem_rdata;
						else
							state_next = ST_LOAD;
					end
					cbl_pkg::OP_LDPRE:
					begin
						{rf_next[ptr_lo(ins.ptr) + 5'h01], rf_next[ptr_lo(ins.ptr)]}
							= ptr - 16'h0001;
						addr_next  = ptr - 16'h0001;
						state_next = ST_LOAD;
					end
					cbl_pkg::OP_RET, cbl_pkg::OP_IRET:
					begin
						iret_next  = (ins.op == cbl_pkg::OP_IRET);
						state_next = ST_POPH;
					end
					default:
						state_next = ST_EXEC;
				endcase
			end
			ST_SKIP:
			begin
				// the skipped word tells whether a second word follows
				pc_next    = pc_reg + (ins.two_word ? 16'h0002 : 16'h0001);
				state_next = ins.two_word ? ST_SKIP2 : ST_EXEC;
			end
			ST_SKIP2:
				state_next = ST_EXEC;
			ST_BRTAKE:
				state_next = ST_EXEC;
			ST_IOTEST:
			begin
				dmem.req  = 1'b1;
				dmem.addr = addr_reg;
				if (dmem_ready)
					state_next = (dmem_rdata[bsel_reg] == want_reg) ?
						ST_SKIP : ST_EXEC;
			end
			ST_LOAD:
			begin
				// slow memory stretches the load by holding ready low
				dmem.req  = 1'b1;
				dmem.addr = addr_reg;
				if (dmem_ready)
				begin
					rf_next[dst_reg] = dmem_rdata;
					state_next = ST_EXEC;
				end
			end
			ST_POPH:
			begin
				dmem.req  = 1'b1;
				dmem.addr = sp_reg + 16'h0001;
				if (dmem_ready)
				begin
					pch_next   = dmem_rdata;
					state_next = ST_POPL;
				end
			end
			ST_POPL:
			begin
				dmem.req  = 1'b1;
				dmem.addr = sp_reg + 16'h0002;
				if (dmem_ready)
				begin
					pc_next    = {pch_reg, dmem_rdata};
					sp_next    = sp_reg + 16'h0002;
					state_next = ST_RETEND;
				end
			end
			ST_RETEND:
			begin
				if (iret_reg)
					flags_next[cbl_pkg::F_I] = 1'b1;
				state_next = ST_EXEC;
			end
			default:
				state_next = ST_EXEC;
		endcase
	end

	// state registers only
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_reg <= ST_EXEC;
			pc_reg    <= cbl_pkg::PC_RST;
			sp_reg    <= cbl_pkg::SP_RST;
			addr_reg  <= 16'h0000;
			flags_reg <= cbl_pkg::FLAGS_RST;
			dst_reg   <= 5'h00;
			bsel_reg  <= 3'h0;
			want_reg  <= 1'b0;
			iret_reg  <= 1'b0;
			pch_reg   <= 8'h00;
			rf_reg    <= '0;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg    <= pc_next;
			sp_reg    <= sp_next;
			addr_reg  <= addr_next;
			flags_reg <= flags_next;
			dst_reg   <= dst_next;
			bsel_reg  <= bsel_next;
			want_reg  <= want_next;
			iret_reg  <= iret_next;
			pch_reg   <= pch_next;
			rf_reg    <= rf_next;
		end
	end

	// checks, all on clk_sys
	logic ex;
	assign ex = (state_reg == ST_EXEC);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	AST_EQ_SKIP: assert property (ex && ins.op == cbl_pkg::OP_CMPSKIP && !flags_wr
		&& rf_reg[ins.rd] == rf_reg[ins.rr] |=> state_reg == ST_SKIP
		&& flags_reg == $past(flags_reg)) else $error("equal compare did not skip");
	AST_CMP_NOWB: assert property (ex && ins.op == cbl_pkg::OP_CP
		|=> rf_reg == $past(rf_reg) && flags_reg == $past(cmp_flags)
		&& state_reg == ST_EXEC) else $error("compare wrote a register");
	AST_RBIT_SKIP: assert property (ex && ins.op == cbl_pkg::OP_SRBS
		&& rf_reg[ins.rr][ins.bsel] |=> state_reg == ST_SKIP)
		else $error("set bit did not skip");
	AST_IO_EXTRA: assert property (ex && ins.op == cbl_pkg::OP_SIOC
		|=> state_reg == ST_IOTEST) else $error("io skip missed its read cycle");
	AST_BR_TAKEN: assert property (ex && br_hit
		|=> pc_reg == $past(br_target) && state_reg == ST_BRTAKE
		##1 state_reg == ST_EXEC) else $error("taken branch wrong");
	AST_BR_NOT: assert property (ex && ins.op == cbl_pkg::OP_BRCLR
		&& !br_hit |=> pc_reg == $past(pc_reg) + 16'h0001
		&& state_reg == ST_EXEC) else $error("untaken branch wrong");
	AST_SIGNED_GE: assert property (ex && ins.op == cbl_pkg::OP_BRSGE
		&& flags_reg[cbl_pkg::F_N] == flags_reg[cbl_pkg::F_V]
		|=> state_reg == ST_BRTAKE) else $error("signed ge not taken");
	AST_CONST_ONE: assert property (ex && ins.op == cbl_pkg::OP_LDCONST
		|=> rf_reg[$past(ins.rd)] == $past(ins.imm) && state_reg == ST_EXEC)
		else $error("constant load wrong");
	AST_PREDEC: assert property (ex && ins.op == cbl_pkg::OP_LDPRE
		|=> dmem.req && dmem.addr == $past(ptr) - 16'h0001)
		else $error("pre-decrement address wrong");
	AST_IRET_I: assert property (state_reg == ST_RETEND && iret_reg
		&& !flags_wr |=> flags_reg[cbl_pkg::F_I]) else $error("irq return left I clear");
	AST_LDD_NOM: assert property (ex && ins.op == cbl_pkg::OP_LDD
		##1 dmem_ready |=> state_reg == ST_EXEC) else $error("direct load too slow");

	COV_SKIP2: cover property (state_reg == ST_SKIP ##1 state_reg == ST_SKIP2);
	COV_BRANCH: cover property (ex && br_hit);
	COV_LOADWAIT: cover property (state_reg == ST_LOAD && !dmem_ready);
	COV_IRET: cover property (state_reg == ST_RETEND && iret_reg);
endmodule : cbl_exec

// ---- logic/cbl_pkg.sv ----
// shared constants and types of the compare, branch and load execution core
package cbl_pkg;
	localparam int          PC_W      = 16;
	localparam int          NREG      = 32;
	// status flag bit positions
	localparam int          F_C       = 0;
	localparam int          F_Z       = 1;
	localparam int          F_N       = 2;
	localparam int          F_V       = 3;
	localparam int          F_S       = 4;
	localparam int          F_H       = 5;
	localparam int          F_T       = 6;
	localparam int          F_I       = 7;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	// pointer selectors and the low register of each pointer pair
	localparam logic [1:0]  PSEL_X    = 2'h0;
	localparam logic [1:0]  PSEL_Y    = 2'h1;
	localparam logic [1:0]  PSEL_Z    = 2'h2;
	localparam logic [4:0]  PTR_X_LO  = 5'h1A;
	localparam logic [4:0]  PTR_Y_LO  = 5'h1C;
	localparam logic [4:0]  PTR_Z_LO  = 5'h1E;
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam logic [15:0] SP_RST    = 16'h0FFF;
	localparam logic [15:0] IO_BASE   = 16'h0000;

	typedef enum logic [4:0] {
		OP_NOP, OP_CMPSKIP, OP_CP, OP_CMPCARRY, OP_CMPIMM,
		OP_SRBC, OP_SRBS, OP_SIOC, OP_SIOS,
		OP_BRSET, OP_BRCLR, OP_BRSGE, OP_BRSLT,
		OP_MOV, OP_CPYPAIR, OP_LDCONST, OP_LDD,
		OP_LDP, OP_LDPOST, OP_LDPRE, OP_RET, OP_IRET
	} cbl_op_t;

	// pre-decoded instruction as delivered by program memory
	typedef struct packed {
		cbl_op_t     op;
		logic [4:0]  rd;
		logic [4:0]  rr;
		logic [7:0]  imm;
		logic [2:0]  bsel;
		logic [1:0]  ptr;
		logic [6:0]  koff;
		logic [15:0] addr;
		logic        two_word;
	} cbl_instr_t;

	// data space read request
	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} cbl_dreq_t;
endpackage : cbl_pkg

// ---- sim/cbl_dmem_model.sv ----
// data space model: address-derived bytes, optional one-cycle wait
`timescale 1ns/100ps
module cbl_dmem_model (
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	input  wire logic               slow,
	input  wire cbl_pkg::cbl_dreq_t dmem,
	output logic              [7:0] dmem_rdata,
	output logic                    dmem_ready
);
	logic       wait_reg;
	logic [7:0] junk_reg;
	// a slow access is answered on its second cycle
	always_ff @(posedge clk_sys)
	begin
		wait_reg <= !sys_rst && dmem.req && !dmem_ready;
		junk_reg <= sys_rst ? 8'h00 : junk_reg + 8'h3B;
	end
	assign dmem_ready = !slow || wait_reg;
	// unselected data churns so a stale byte can never pass
	assign dmem_rdata = dmem.req ?
		dmem.addr[7:0] ^ dmem.addr[15:8] ^ 8'h5A : junk_reg;
endmodule : cbl_dmem_model

// ---- sim/tb_cbl_exec.sv ----
// bench for the compare, branch and load core
`timescale 1ns/100ps
module tb_cbl_exec;
	logic                clk_sys;
	logic                sys_rst;
	logic         [15:0] pc;
	cbl_pkg::cbl_instr_t prog_instr;
	cbl_pkg::cbl_dreq_t  dmem;
	logic          [7:0] dmem_rdata;
	logic                dmem_ready;
	logic                flags_wr;
	logic          [7:0] flags_wdata;
	logic          [7:0] status_flags;
	logic          [4:0] peek_sel;
	logic          [7:0] peek_data;
	logic                slow;
	cbl_pkg::cbl_instr_t prog [64];
	int                  n_errors = 0;
	int                  check_count = 0;
	int                  cyc = 0;

	// program store answers the fetch in the same cycle
	assign prog_instr = prog[pc[5:0]];
	cbl_exec DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .pc(pc),
		.prog_instr(prog_instr), .dmem(dmem), .dmem_rdata(dmem_rdata),
		.dmem_ready(dmem_ready), .flags_wr(flags_wr),
		.flags_wdata(flags_wdata), .status_flags(status_flags),
		.peek_sel(peek_sel), .peek_data(peek_data));
	cbl_dmem_model mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
		.dmem(dmem), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready));

	function automatic logic [7:0] mdat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : mdat
	function automatic cbl_pkg::cbl_instr_t mk(input cbl_pkg::cbl_op_t op,
		input logic [4:0] rd, input logic [4:0] rr, input logic [7:0] im);
		return '{op, rd, rr, im, 3'h0, 2'h0, 7'h00, 16'h0000, 1'b0};
	endfunction : mk

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic pk(input logic [4:0] r, input logic [7:0] e);
		@(posedge clk_sys);
		peek_sel <= r;
		#1;
		chk(peek_data, e);
	endtask : pk
	// reset, then load flags while the nop at address 0 runs
	task automatic start(input logic [7:0] f);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		flags_wr <= 1'b1;
		flags_wdata <= f;
		@(posedge clk_sys);
		flags_wr <= 1'b0;
	endtask : start
	task automatic clr;
		for (int i = 0; i < 64; i++)
			prog[i] = mk(cbl_pkg::OP_NOP, 5'h00, 5'h00, 8'h00);
	endtask : clr

	// each flag in both senses and values, then the signed pair
	task automatic t_branch;
		logic [7:0]  f;
		logic [6:0]  k;
		logic        tk;
		logic [15:0] e;
		for (int i = 0; i < 40; i++)
		begin
			clr();
			f = i[4] ? 8'h01 << i[2:0] : ~(8'h01 << i[2:0]);
			tk = i[4] ^ i[3];
			k = 7'h05;
			prog[1] = mk(i[3] ? cbl_pkg::OP_BRCLR : cbl_pkg::OP_BRSET,
				5'h00, 5'h00, 8'h00);
			prog[1].bsel = i[2:0];
			if (i >= 32)
			begin
				f = {4'h0, i[2], i[1], 2'h0};
				tk = (i[1] ^ i[2]) == i[0];
				k = 7'h7E; // backwards jump to address 0
				prog[1].op = i[0] ? cbl_pkg::OP_BRSLT : cbl_pkg::OP_BRSGE;
			end
			prog[1].koff = k;
			e = 16'h0002 + {{9{k[6]}}, k};
			start(f);
			step(1);
			chk(pc, tk ? e : 16'h0002);
			step(1);
			chk(pc, tk ? e : 16'h0003);
			chk(status_flags, f);
		end
		$display("branch test done");
	endtask : t_branch

	// one skip case; a two-word follower only where the skip happens
	task automatic sk(input cbl_pkg::cbl_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic [2:0] bs, input logic w);
		logic [7:0]  io;
		logic        s;
		logic        x;
		logic [15:0] t;
		io = mdat(cbl_pkg::IO_BASE + {10'h000, a[5:0]});
		x = op == cbl_pkg::OP_SIOC || op == cbl_pkg::OP_SIOS;
		case (op)
			cbl_pkg::OP_CMPSKIP: s = a == b;
			cbl_pkg::OP_SRBC: s = !a[bs];
			cbl_pkg::OP_SRBS: s = a[bs];
			cbl_pkg::OP_SIOC: s = !io[bs];
			default:          s = io[bs];
		endcase
		clr();
		prog[1] = mk(cbl_pkg::OP_LDCONST, 5'h10, 5'h00, a);
		prog[2] = mk(cbl_pkg::OP_LDCONST, 5'h11, 5'h00, b);
		prog[3] = mk(op, 5'h10, 5'h11, 8'h00);
		prog[3].bsel = bs;
		prog[3].addr = {8'h00, a};
		prog[4] = mk(w ? cbl_pkg::OP_LDD : cbl_pkg::OP_MOV, 5'h14, 5'h14, 8'h00);
		prog[4].two_word = w;
		t = s ? 16'h0005 + w : 16'h0004;
		start(8'hC3);
		step(3 + (s ? 1 + w : 0) + x);
		chk(pc, t);
		chk(status_flags, 8'hC3);
		step(1);
		chk(pc, t + 16'h0001);
		$display("skip case done");
	endtask : sk

	// flags from the subtraction; Z before a carry-in compare is its inverse
	task automatic cm(input cbl_pkg::cbl_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic ci);
		logic [7:0] f;
		logic [7:0] r;
		logic [7:0] e;
		logic       c;
		logic       v;
		f = ci ? 8'h81 : 8'h82;
		c = op == cbl_pkg::OP_CMPCARRY && ci;
		r = a - b - c;
		v = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
		e = {f[7:6], (!a[3] & b[3]) | (b[3] & r[3]) | (r[3] & !a[3]), r[7] ^ v,
			v, r[7], r == 0 && (op != cbl_pkg::OP_CMPCARRY || f[1]),
			{1'b0, a} < {1'b0, b} + c};
		clr();
		prog[1] = mk(cbl_pkg::OP_LDCONST, 5'h10, 5'h00, a);
		prog[2] = mk(cbl_pkg::OP_LDCONST, 5'h11, 5'h00, b);
		prog[3] = mk(op, 5'h10, 5'h11, b);
		start(f);
		step(3);
		chk(status_flags, e);
		chk(pc, 16'h0004);
		pk(5'h10, a);
		$display("compare case done");
	endtask : cm

	// pointer, post-increment, pre-decrement and direct loads, fast and slow
	task automatic t_load;
		logic [15:0] pt [8];
		int          dl [8];
		pt = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0009,
			16'h000A, 16'h000B};
		dl = '{2, 1, 1, 1, 2, 2, 1, 1};
		clr();
		prog[1] = mk(cbl_pkg::OP_LDCONST, 5'h1A, 5'h00, 8'h40);
		prog[2] = mk(cbl_pkg::OP_LDCONST, 5'h1B, 5'h00, 8'h01);
		prog[3] = mk(cbl_pkg::OP_LDP, 5'h00, 5'h00, 8'h00);
		prog[4] = mk(cbl_pkg::OP_LDPOST, 5'h01, 5'h00, 8'h00);
		prog[5] = mk(cbl_pkg::OP_CPYPAIR, 5'h04, 5'h1A, 8'h00);
		prog[6] = mk(cbl_pkg::OP_LDPRE, 5'h02, 5'h00, 8'h00);
		prog[7] = mk(cbl_pkg::OP_LDD, 5'h03, 5'h00, 8'h00);
		prog[7].addr = 16'h0234;
		prog[7].two_word = 1'b1;
		prog[9] = mk(cbl_pkg::OP_CPYPAIR, 5'h06, 5'h1A, 8'h00);
		prog[10] = mk(cbl_pkg::OP_MOV, 5'h08, 5'h03, 8'h00);
		for (int sl = 0; sl < 2; sl++)
		begin
			slow <= sl[0];
			start(8'h00);
			// each data read costs one extra cycle when memory is slow
			for (int i = 0; i < 8; i++)
			begin
				step(dl[i] + ((sl == 1 && i inside {1, 2, 4, 5}) ? 1 : 0));
				chk(pc, pt[i]);
			end
			pk(5'h00, mdat(16'h0140));
			pk(5'h01, mdat(16'h0140));
			pk(5'h04, 8'h41);
			pk(5'h05, 8'h01);
			pk(5'h02, mdat(16'h0140));
			pk(5'h06, 8'h40);
			pk(5'h03, mdat(16'h0234));
			pk(5'h08, mdat(16'h0234));
		end
		slow <= 1'b0;
		$display("load test done");
	endtask : t_load

	// return pops high byte then low byte above the reset stack pointer
	task automatic rt(input cbl_pkg::cbl_op_t op);
		logic [15:0] t;
		t = {mdat(16'h1000), mdat(16'h1001)};
		clr();
		prog[1] = mk(op, 5'h00, 5'h00, 8'h00);
		start(8'h00);
		step(4);
		chk(pc, t);
		chk(status_flags[7], op == cbl_pkg::OP_IRET);
		step(1);
		chk(pc, t + 16'h0001);
		$display("return case done");
	endtask : rt

	task automatic complete_run;
		$display("%0d checks, %0d mismatches", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// hang guard, far above the few hundred cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			$display("unexpected at %0t: run did not finish", $time);
			complete_run();
		end
	end
	initial
	begin
		sys_rst = 1'b1;
		flags_wr = 1'b0;
		flags_wdata = 8'h00;
		peek_sel = 5'h00;
		slow = 1'b0;
		clr();
		repeat (10) @(posedge clk_sys);
		t_branch();
		sk(cbl_pkg::OP_CMPSKIP, 8'h3C, 8'h3C, 3'h0, 1'b0);
		sk(cbl_pkg::OP_CMPSKIP, 8'h3C, 8'h3C, 3'h0, 1'b1);
		sk(cbl_pkg::OP_CMPSKIP, 8'h3C, 8'h3D, 3'h0, 1'b0);
		sk(cbl_pkg::OP_SRBC, 8'h80, 8'h80, 3'h7, 1'b0);
		sk(cbl_pkg::OP_SRBC, 8'h80, 8'h80, 3'h0, 1'b1);
		sk(cbl_pkg::OP_SRBS, 8'h80, 8'h80, 3'h7, 1'b0);
		sk(cbl_pkg::OP_SRBS, 8'h80, 8'h80, 3'h0, 1'b0);
		sk(cbl_pkg::OP_SIOS, 8'h12, 8'h12, 3'h3, 1'b1);
		sk(cbl_pkg::OP_SIOS, 8'h12, 8'h12, 3'h0, 1'b0);
		sk(cbl_pkg::OP_SIOC, 8'h12, 8'h12, 3'h0, 1'b0);
		sk(cbl_pkg::OP_SIOC, 8'h12, 8'h12, 3'h3, 1'b0);
		cm(cbl_pkg::OP_CP, 8'h05, 8'h05, 1'b0);
		cm(cbl_pkg::OP_CP, 8'h80, 8'h01, 1'b0);
		cm(cbl_pkg::OP_CMPCARRY, 8'h05, 8'h04, 1'b1);
		cm(cbl_pkg::OP_CMPCARRY, 8'h00, 8'h00, 1'b0);
		cm(cbl_pkg::OP_CMPIMM, 8'h10, 8'h01, 1'b0);
		cm(cbl_pkg::OP_CMPIMM, 8'h7F, 8'hFF, 1'b0);
		t_load();
		rt(cbl_pkg::OP_RET);
		rt(cbl_pkg::OP_IRET);
		complete_run();
	end
endmodule : tb_cbl_exec
